//--- logic/lpmc_ctrl.sv
// Low power mode controller: sleep, deep-sleep and deep power-down sequencing.
// Assumes resetn is driven by the reset pin and by brownout and watchdog resets.
//
// What this block does
// RULE_01: Sleep stops processor clock until interrupt or reset.
// RULE_02: Kept-clocked peripherals run and wake in sleep.
// RULE_03: Sleep and deep-sleep retain state and freeze pins.
// RULE_04: Deep-sleep stops main, peripheral clocks; flash standby.
// RULE_05: Deep-sleep powers down analog unless kept running.
// RULE_06: Listed wake-capable units may stay running if selected.
// RULE_07: Serial units off; slave modes may still wake.
// RULE_08: Deep power-down keeps only RTC and reset domain; the code keeps RTC power only when rtc_osc_keep is set.
// RULE_09: Deep power-down exits only by reset or alarm.
// RULE_10: Second alarm flag raises RTC wake request.
// RULE_11: Deep power-down loses contents; pins high impedance.
// RULE_12: Sleep wakes on enabled interrupt or serial wake.
// RULE_13: Pin wake needs controller and start mask enables.
// RULE_14: Brownout wake needs controller, mask, control enables; the code ties the brownout start-mask bit to 1.
// RULE_15: Brownout reset wake needs reset enable first.
// RULE_16: Watchdog interrupt wake needs oscillator, enables, feed.
// RULE_17: Watchdog reset wake needs enable, reset, feed.
// RULE_18: Masked wake restores clocks before releasing processor.
`timescale 1ns/100ps
`include "lpmc_cfg.svh"
module lpmc_ctrl (
    // Clock and reset.
    input  wire logic                     clock,
    input  wire logic                     resetn,
    // Mode request from the processor.
    input  wire lpmc_pkg::lpmc_req_e      mode_req,
    input  wire logic                     mode_go,
    // Configuration.
    input  wire logic [`LPMC_NPERIPH-1:0] periph_keep_clk,
    input  wire logic [`LPMC_NANALOG-1:0] analog_keep_on,
    input  wire logic                     watchdog_osc_keep,
    input  wire logic                     brownout_keep,
    input  wire logic                     rtc_osc_keep,
    input  wire logic                     serial_slave_mode,
    input  wire logic [7:0]               start_logic_mask_0,
    input  wire logic [7:0]               start_logic_mask_1,
    input  wire logic [`LPMC_NSRC-1:0]    irq_enable,
    // Wake sources.
    input  wire logic [7:0]               pin_irq,
    input  wire logic                     group_irq,
    input  wire logic                     brownout_irq,
    input  wire logic                     watchdog_irq,
    input  wire logic                     utick_irq,
    input  wire logic                     usb_need_clk,
    input  wire logic                     serial_irq,
    input  wire logic                     serial_hw_wake_request,
    input  wire logic                     rtc_second_alarm_flag,
    // Controls to the rest of the chip.
    output logic                          cpu_clk_en,
    output logic                          cpu_halt,
    output logic                          main_clk_en,
    output logic [`LPMC_NPERIPH-1:0]      periph_clk_en,
    output logic [`LPMC_NANALOG-1:0]      analog_pwr_en,
    output logic                          watchdog_osc_en,
    output logic                          brownout_en,
    output logic                          serial_pwr_en,
    output logic                          flash_standby,
    output logic                          retain_en,
    output logic                          pin_hold,
    output logic                          pin_hiz,
    output logic                          core_pwr_en,
    output logic                          rtc_pwr_en,
    output logic                          rtc_wake_irq,
    output lpmc_pkg::lpmc_state_e         mode_state
);
    localparam int SETTLE = (`LPMC_CLK_SETTLE_CYC < 1) ? 1 : `LPMC_CLK_SETTLE_CYC;

    lpmc_pkg::lpmc_state_e st_reg;
    lpmc_pkg::lpmc_state_e st_next;
    logic [3:0]            cnt_reg;
    logic [3:0]            cnt_next;
    logic                  alarm_d_reg;
    logic                  rtc_irq_reg;
    logic                  is_sleep;
    logic                  is_deep;
    logic                  is_dpd;
    logic                  is_wake;
    logic                  wake;
    lpmc_pkg::lpmc_src_t   pend;
    lpmc_pkg::lpmc_src_t   mask;

    lpmc_wake_if wif ();

    // Serial interrupts wake only in a slave mode; serial_hw_wake_request wakes in any mode.
    wire serial_wake = serial_irq & serial_slave_mode;                  // [RULE_07]
    wire alarm_rise  = rtc_second_alarm_flag & ~alarm_d_reg;

    assign pend = {1'b0, usb_need_clk, serial_wake, utick_irq, rtc_irq_reg,
                   watchdog_irq, brownout_irq, group_irq, pin_irq};     // [RULE_06]
    assign mask = {{(`LPMC_NSRC-`LPMC_NPERIPH-1){1'b1}}, start_logic_mask_1[0],
                   start_logic_mask_0};                                 // [RULE_13]
    assign wif.pending    = pend | {2'b00, serial_hw_wake_request, 13'h0000};
    assign wif.irq_enable = irq_enable | {2'b00, 1'b1, 13'h0000};
    assign wif.start_mask = mask | {2'b00, 1'b1, 13'h0000};
    assign wif.deep       = is_deep;
    assign wake           = wif.wake;

    lpmc_wake_qual u_qual (
        .w (wif)
    );

    assign is_sleep = (st_reg == lpmc_pkg::LPMC_ST_SLEEP);
    assign is_deep  = (st_reg == lpmc_pkg::LPMC_ST_DEEP);
    assign is_dpd   = (st_reg == lpmc_pkg::LPMC_ST_DPD);
    assign is_wake  = (st_reg == lpmc_pkg::LPMC_ST_WAKE);

    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        unique case (st_reg)
            lpmc_pkg::LPMC_ST_ACTIVE: begin
                if (mode_go) begin
                    unique case (mode_req)
                        lpmc_pkg::LPMC_REQ_SLEEP: st_next = lpmc_pkg::LPMC_ST_SLEEP;
                        lpmc_pkg::LPMC_REQ_DEEP:  st_next = lpmc_pkg::LPMC_ST_DEEP;
                        lpmc_pkg::LPMC_REQ_DPD:   st_next = lpmc_pkg::LPMC_ST_DPD;
                        lpmc_pkg::LPMC_REQ_NONE:  st_next = lpmc_pkg::LPMC_ST_ACTIVE;
                    endcase
                end
            end
            lpmc_pkg::LPMC_ST_SLEEP: begin
                if (wake) begin                                         // [RULE_01]
                    st_next = lpmc_pkg::LPMC_ST_ACTIVE;
                end
            end
            lpmc_pkg::LPMC_ST_DEEP: begin
                if (wake) begin                                         // [RULE_18]
                    st_next  = lpmc_pkg::LPMC_ST_WAKE;
                    cnt_next = 4'(SETTLE);
                end
            end
            lpmc_pkg::LPMC_ST_DPD: begin
                if (rtc_irq_reg) begin                                  // [RULE_09]
                    st_next  = lpmc_pkg::LPMC_ST_WAKE;
                    cnt_next = 4'(SETTLE);
                end
            end
            lpmc_pkg::LPMC_ST_WAKE: begin
                if (cnt_reg <= 4'h1) begin                              // [RULE_18]
                    st_next  = lpmc_pkg::LPMC_ST_ACTIVE;
                    cnt_next = 4'h0;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: st_next = lpmc_pkg::LPMC_ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg      <= lpmc_pkg::LPMC_ST_ACTIVE;
            cnt_reg     <= 4'h0;
            alarm_d_reg <= 1'b0;
            rtc_irq_reg <= 1'b0;
        end else begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            alarm_d_reg <= rtc_second_alarm_flag;
            // Alarm request holds until the processor runs again; set wins.
            rtc_irq_reg <= alarm_rise | (rtc_irq_reg & ~(st_reg == lpmc_pkg::LPMC_ST_ACTIVE)); // [RULE_10]
        end
    end

    // Processor clock only in active state, after clocks are restored.
    assign cpu_clk_en    = (st_reg == lpmc_pkg::LPMC_ST_ACTIVE);         // [RULE_01]
    assign cpu_halt      = ~cpu_clk_en;                                  // [RULE_18]
    assign main_clk_en   = ~(is_deep | is_dpd);                          // [RULE_04]
    assign periph_clk_en = is_sleep ? periph_keep_clk                    // [RULE_02]
                         : ((is_deep | is_dpd) ? '0 : {`LPMC_NPERIPH{1'b1}}); // [RULE_04]
    assign analog_pwr_en = is_dpd ? '0
                         : (is_deep ? analog_keep_on : {`LPMC_NANALOG{1'b1}}); // [RULE_05]
    assign watchdog_osc_en = is_dpd ? 1'b0 : (is_deep ? watchdog_osc_keep : 1'b1); // [RULE_06]
    assign brownout_en   = is_dpd ? 1'b0 : (is_deep ? brownout_keep : 1'b1);      // [RULE_14]
    assign serial_pwr_en = ~(is_deep | is_dpd);                          // [RULE_07]
    assign flash_standby = is_deep;                                      // [RULE_04]
    assign retain_en     = ~is_dpd;                                      // [RULE_03]
    assign pin_hold      = is_sleep | is_deep;                           // [RULE_03]
    assign pin_hiz       = is_dpd;                                       // [RULE_11]
    assign core_pwr_en   = ~is_dpd;                                      // [RULE_08]
    assign rtc_pwr_en    = ~is_dpd | rtc_osc_keep;                       // [RULE_08]
    assign rtc_wake_irq  = rtc_irq_reg;                                  // [RULE_10]
    assign mode_state    = st_reg;

    property p_sleep_clk_off;
        @(posedge clock) disable iff (!resetn)
        is_sleep |-> !cpu_clk_en && pin_hold;
    endproperty
    a_sleep_clk_off: assert property (p_sleep_clk_off) else $error("cpu clock on in sleep"); // [RULE_01]

    property p_sleep_periph;
        @(posedge clock) disable iff (!resetn)
        is_sleep |-> periph_clk_en == periph_keep_clk;
    endproperty
    a_sleep_periph: assert property (p_sleep_periph) else $error("sleep clocks wrong"); // [RULE_02]

    property p_retain;
        @(posedge clock) disable iff (!resetn)
        (is_sleep || is_deep) |-> retain_en && pin_hold && !pin_hiz;
    endproperty
    a_retain: assert property (p_retain) else $error("retention lost"); // [RULE_03]

    property p_deep_clocks;
        @(posedge clock) disable iff (!resetn)
        is_deep |-> !main_clk_en && periph_clk_en == '0 && flash_standby;
    endproperty
    a_deep_clocks: assert property (p_deep_clocks) else $error("deep clocks on"); // [RULE_04]

    property p_deep_analog;
        @(posedge clock) disable iff (!resetn)
        is_deep |-> analog_pwr_en == analog_keep_on && !serial_pwr_en;
    endproperty
    a_deep_analog: assert property (p_deep_analog) else $error("analog power wrong"); // [RULE_05]

    property p_dpd_off;
        @(posedge clock) disable iff (!resetn)
        is_dpd |-> !core_pwr_en && pin_hiz && !retain_en && !watchdog_osc_en;
    endproperty
    a_dpd_off: assert property (p_dpd_off) else $error("power on in deep power-down"); // [RULE_08]

    property p_dpd_exit;
        @(posedge clock) disable iff (!resetn)
        is_dpd && !rtc_irq_reg |=> is_dpd;
    endproperty
    a_dpd_exit: assert property (p_dpd_exit) else $error("bad deep power-down exit"); // [RULE_09]

    sequence s_alarm;
        rtc_second_alarm_flag && !alarm_d_reg;
    endsequence
    property p_alarm_irq;
        @(posedge clock) disable iff (!resetn)
        s_alarm |=> rtc_wake_irq;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm not raised"); // [RULE_10]

    sequence s_deep_wake;
        is_deep && wake;
    endsequence
    property p_wake_order;
        @(posedge clock) disable iff (!resetn)
        s_deep_wake |=> main_clk_en && !cpu_clk_en ##[1:15] cpu_clk_en;
    endproperty
    a_wake_order: assert property (p_wake_order) else $error("wake order wrong"); // [RULE_18]

    property p_sleep_wake;
        @(posedge clock) disable iff (!resetn)
        is_sleep && serial_hw_wake_request |=> cpu_clk_en;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("serial wake missed"); // [RULE_12]
endmodule

//--- logic/lpmc_cfg.svh
// Constants for the low power mode controller: source positions and timing counts.
// Assumes inclusion by bare name from the package and design files.
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH
`define LPMC_NSRC          16
`define LPMC_SRC_PIN_LO    0
`define LPMC_SRC_GROUP     8
`define LPMC_SRC_BROWNOUT  9
`define LPMC_SRC_WATCHDOG  10
`define LPMC_SRC_RTC       11
`define LPMC_SRC_UTICK     12
`define LPMC_SRC_SERIAL    13
`define LPMC_SRC_USB       14
`define LPMC_SRC_SPARE     15
`define LPMC_NPERIPH       8
`define LPMC_NANALOG       4
`define LPMC_CLK_SETTLE_NS 100
`define LPMC_CLK_PERIOD_NS 20
`define LPMC_CLK_SETTLE_CYC ((`LPMC_CLK_SETTLE_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS)
`endif

//--- logic/lpmc_pkg.sv
// Types shared by the low power mode controller files.
// Assumes lpmc_cfg.svh is on the include path.
`include "lpmc_cfg.svh"
package lpmc_pkg;
    typedef enum logic [1:0] {
        LPMC_REQ_NONE  = 2'b00,
        LPMC_REQ_SLEEP = 2'b01,
        LPMC_REQ_DEEP  = 2'b10,
        LPMC_REQ_DPD   = 2'b11
    } lpmc_req_e;
    typedef enum logic [2:0] {
        LPMC_ST_ACTIVE = 3'b000,
        LPMC_ST_SLEEP  = 3'b001,
        LPMC_ST_DEEP   = 3'b010,
        LPMC_ST_DPD    = 3'b011,
        LPMC_ST_WAKE   = 3'b100
    } lpmc_state_e;
    typedef logic [`LPMC_NSRC-1:0] lpmc_src_t;
endpackage

//--- logic/lpmc_wake_if.sv
// Interface carrying wake sources and masks into the qualifier.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
`include "lpmc_cfg.svh"
interface lpmc_wake_if;
    lpmc_pkg::lpmc_src_t pending;
    lpmc_pkg::lpmc_src_t irq_enable;
    lpmc_pkg::lpmc_src_t start_mask;
    logic                deep;
    logic                wake;
    modport ctrl (output pending, output irq_enable, output start_mask, output deep, input wake);
    modport qual (input pending, input irq_enable, input start_mask, input deep, output wake);
endinterface

//--- logic/lpmc_wake_qual.sv
// Wake qualification: combines pending sources with interrupt enables and start masks.
// Assumes inputs are synchronous to the controller clock.
`timescale 1ns/100ps
`include "lpmc_cfg.svh"
module lpmc_wake_qual (
    lpmc_wake_if.qual w
);
    wire [`LPMC_NSRC-1:0] sleep_hit;
    wire [`LPMC_NSRC-1:0] deep_hit;
    wire                  serial_hit;
    // Sleep wakes on any enabled interrupt or a serial hardware wake.
    assign sleep_hit  = w.pending & w.irq_enable;                       // [RULE_12]
    assign serial_hit = w.pending[`LPMC_SRC_SERIAL];                    // [RULE_12]
    // Deep-sleep needs the start-logic mask as well.
    assign deep_hit   = w.pending & w.irq_enable & w.start_mask;        // [RULE_18]
    assign w.wake     = w.deep ? ((|deep_hit) | serial_hit)
                               : ((|sleep_hit) | serial_hit);
endmodule

//--- verif/lpmc_src_model.sv
// Partner model of the wake sources seen by the core and its interrupt controller.
// Assumes the bench fires one source at a time; the core services it once running.
`timescale 1ns/100ps
module lpmc_src_model (
    // Clock and bench control.
    input  wire logic       clock,
    input  wire logic       fire,
    input  wire logic [3:0] fire_idx,
    input  wire logic       clr,
    // Core running indication.
    input  wire logic       cpu_clk_en,
    // Source levels, bit map as the controller expects.
    output logic [15:0]     pend = 16'h0000
);
    // A raised source stays high until the bench pulses clr or the core is running.
    always @(posedge clock) begin
        if (clr || cpu_clk_en) begin
            pend <= 16'h0000;
        end else if (fire) begin
            pend[fire_idx] <= 1'b1;
        end
    end
endmodule

//--- verif/low_power_mode_controller_tb.sv
// Self-checking bench for the low power mode controller.
// Assumes the design files and lpmc_src_model are compiled first.
`timescale 1ns/100ps
module low_power_mode_controller_tb;
    logic                clock = 1'b0;
    logic                resetn = 1'b0;
    lpmc_pkg::lpmc_req_e mode_req = lpmc_pkg::LPMC_REQ_NONE;
    logic                mode_go = 1'b0;
    logic [7:0]          keep_clk = 8'h5a;
    logic [3:0]          ana_keep = 4'h9;
    logic                wd_keep = 1'b1;
    logic                bo_keep = 1'b1;
    logic                rtc_keep = 1'b1;
    logic                slave = 1'b0;
    logic [7:0]          mask0 = 8'h00;
    logic [7:0]          mask1 = 8'h00;
    logic [15:0]         irq_en = 16'h0000;
    logic                fire = 1'b0;
    logic [3:0]          fire_idx = 4'h0;
    logic                clr = 1'b0;
    logic [15:0]         pend;
    logic                cpu_clk_en, cpu_halt, main_clk_en, wd_en, bo_en, ser_en, fl_sb;
    logic                retain_en, pin_hold, pin_hiz, core_en, rtc_en, rtc_irq;
    logic [7:0]          per_en;
    logic [3:0]          ana_en;
    lpmc_pkg::lpmc_state_e st;
    int                  n_fail = 0;
    int                  total_checks = 0;
    int                  k;
    logic [3:0]          srcs [7] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he, 4'hf};

    always #10 clock = ~clock;

    lpmc_src_model src (.clock(clock), .fire(fire), .fire_idx(fire_idx), .clr(clr),
        .cpu_clk_en(cpu_clk_en), .pend(pend));

    lpmc_ctrl uut (.clock(clock), .resetn(resetn), .mode_req(mode_req), .mode_go(mode_go),
        .periph_keep_clk(keep_clk), .analog_keep_on(ana_keep), .watchdog_osc_keep(wd_keep),
        .brownout_keep(bo_keep), .rtc_osc_keep(rtc_keep), .serial_slave_mode(slave),
        .start_logic_mask_0(mask0), .start_logic_mask_1(mask1), .irq_enable(irq_en),
        .pin_irq(pend[7:0]), .group_irq(pend[8]), .brownout_irq(pend[9]),
        .watchdog_irq(pend[10]), .rtc_second_alarm_flag(pend[11]), .utick_irq(pend[12]),
        .serial_irq(pend[13]), .usb_need_clk(pend[14]), .serial_hw_wake_request(pend[15]),
        .cpu_clk_en(cpu_clk_en), .cpu_halt(cpu_halt), .main_clk_en(main_clk_en),
        .periph_clk_en(per_en), .analog_pwr_en(ana_en), .watchdog_osc_en(wd_en),
        .brownout_en(bo_en), .serial_pwr_en(ser_en), .flash_standby(fl_sb),
        .retain_en(retain_en), .pin_hold(pin_hold), .pin_hiz(pin_hiz), .core_pwr_en(core_en),
        .rtc_pwr_en(rtc_en), .rtc_wake_irq(rtc_irq), .mode_state(st));

    wire [6:0] modes = {cpu_clk_en, main_clk_en, fl_sb, retain_en, pin_hold, pin_hiz, core_en};

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic enter(input lpmc_pkg::lpmc_req_e m);
        @(negedge clock);
        mode_req = m;
        mode_go = 1'b1;
        @(negedge clock);
        mode_go = 1'b0;
        mode_req = lpmc_pkg::LPMC_REQ_NONE;
        chk({13'h0000, st}, {14'h0000, m});
    endtask

    task automatic raise(input logic [3:0] idx);
        @(negedge clock);
        fire = 1'b1;
        fire_idx = idx;
        @(negedge clock);
        fire = 1'b0;
    endtask

    task automatic no_wake(input logic [3:0] idx);
        lpmc_pkg::lpmc_state_e cur;
        cur = st;
        raise(idx);
        repeat (6) @(negedge clock);
        chk({13'h0000, st}, {13'h0000, cur});
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
    endtask

    task automatic wake_by(input logic [3:0] idx, input lpmc_pkg::lpmc_state_e exp);
        lpmc_pkg::lpmc_state_e cur;
        int n;
        cur = st;
        n = 0;
        raise(idx);
        while (st === cur && n < 6) begin
            @(negedge clock);
            n++;
        end
        chk({13'h0000, st}, {13'h0000, exp});
        n = 0;
        while (st === lpmc_pkg::LPMC_ST_WAKE && n < 20) begin
            chk({14'h0000, main_clk_en, cpu_halt}, 16'h0003);
            @(negedge clock);
            n++;
        end
        if (exp === lpmc_pkg::LPMC_ST_WAKE) chk(n[15:0], 16'h0005);
        chk({13'h0000, st}, {13'h0000, lpmc_pkg::LPMC_ST_ACTIVE});
        chk({9'h000, modes}, 16'h0069);
    endtask

    initial begin
        #(20 * 5000);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (16) @(negedge clock);
        chk({9'h000, modes}, 16'h0069);
        resetn = 1'b1;
        irq_en = 16'h0001;
        enter(lpmc_pkg::LPMC_REQ_SLEEP);
        chk({9'h000, modes}, 16'h002d);
        chk({8'h00, per_en}, {8'h00, keep_clk});
        no_wake(4'h1);
        wake_by(4'h0, lpmc_pkg::LPMC_ST_ACTIVE);
        enter(lpmc_pkg::LPMC_REQ_SLEEP);
        wake_by(4'hf, lpmc_pkg::LPMC_ST_ACTIVE);
        $display("test sleep done");
        irq_en = 16'hffff;
        mask0 = 8'h01;
        enter(lpmc_pkg::LPMC_REQ_DEEP);
        chk({9'h000, modes}, 16'h001d);
        chk({8'h00, per_en}, 16'h0000);
        chk({12'h000, ana_en}, {12'h000, ana_keep});
        chk({13'h0000, wd_en, bo_en, ser_en}, 16'h0006);
        no_wake(4'h2);
        no_wake(4'hd);
        wake_by(4'h0, lpmc_pkg::LPMC_ST_WAKE);
        mask1 = 8'h01;
        slave = 1'b1;
        for (k = 0; k < 7; k++) begin
            enter(lpmc_pkg::LPMC_REQ_DEEP);
            wake_by(srcs[k], lpmc_pkg::LPMC_ST_WAKE);
        end
        ana_keep = 4'h6;
        wd_keep = 1'b0;
        bo_keep = 1'b0;
        enter(lpmc_pkg::LPMC_REQ_DEEP);
        chk({10'h000, ana_en, wd_en, bo_en}, 16'h0018);
        wake_by(4'h0, lpmc_pkg::LPMC_ST_WAKE);
        $display("test deep sleep done");
        enter(lpmc_pkg::LPMC_REQ_DPD);
        chk({9'h000, modes}, 16'h0002);
        chk({11'h000, ana_en, rtc_en}, 16'h0001);
        no_wake(4'h0);
        wake_by(4'hb, lpmc_pkg::LPMC_ST_WAKE);
        chk({15'h0000, rtc_irq}, 16'h0001);
        rtc_keep = 1'b0;
        enter(lpmc_pkg::LPMC_REQ_DPD);
        chk({15'h0000, rtc_en}, 16'h0000);
        resetn = 1'b0;
        @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        chk({13'h0000, st}, 16'h0000);
        chk({9'h000, modes}, 16'h0069);
        $display("test deep power-down done");
        give_verdict();
    end
endmodule
